/* File: mulneg_core.v */
// datapath for multiply, negate and no-operation with an axi4-lite register port
// Notes on behaviour
// - literal multiply: working register times 8-bit constant, unsigned, into product pair
// - product high byte to product_high, low byte to product_low
// - literal multiply leaves working register and flags alone
// - multiplies never touch carry, overflow or zero flags
// - register multiply: working register times addressed byte, unsigned, into product pair
// - register multiply leaves working register, memory byte and flags alone
// - access bit zero uses access bank, one uses bank_selector bank
// - extended mode, access zero, address up to 5fh: indexed literal offset
// - negate writes two's complement back, updates negative, overflow, carry, digit carry, zero
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "mulneg_defs.vh"
module mulneg_core #(
  parameter MEM_DEPTH = 4096
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // execution state
  output wire busy
);
  localparam Q_IDLE = 5'b00001;
  localparam Q_DECODE = 5'b00010;
  localparam Q_READ = 5'b00100;
  localparam Q_PROC = 5'b01000;
  localparam Q_WRITE = 5'b10000;
  localparam K_NO_OPERATION = 4'b0001;
  localparam K_MULL = 4'b0010;
  localparam K_MULW = 4'b0100;
  localparam K_NEG = 4'b1000;
  reg [7:0] mem [0:MEM_DEPTH-1];
  reg [4:0] q_r;
  reg [3:0] kind_r;
  reg [15:0] instr_r;
  reg [7:0] wreg_r;
  reg [3:0] bank_sel_r;
  reg [11:0] fsr2_r;
  reg ext_mode_r;
  reg [4:0] status_r;
  reg [7:0] product_low_r;
  reg [7:0] product_high_r;
  reg [7:0] operand_r;
  reg [15:0] result_r;
  reg [4:0] flags_r;
  reg [11:0] ex_addr_r;
  reg [11:0] mem_addr_r;
  reg illegal_r;
  reg aw_hold_r;
  reg w_hold_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  wire [11:0] ex_addr;
  wire aw_take;
  wire w_take;
  wire wr_fire;
  wire rd_take;
  wire [7:0] neg_val;
  wire [15:0] product;
  ////////////////////////////////////////////////////////////////////////
  // byte-lane merge for register writes
  function [7:0] lane0;
    input [7:0] old;
    input [31:0] d;
    input [3:0] s;
    begin
      lane0 = s[0] ? d[7:0] : old;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // opcode classes
  function [3:0] classify;
    input [15:0] w;
    begin
      if (w == 16'h0000) begin
        classify = K_NO_OPERATION;
      end else if (w[15:12] == `OP_NOPX_NIB) begin
        classify = K_NO_OPERATION;
      end else if (w[15:8] == `OP_MULL_HI) begin
        classify = K_MULL;
      end else if (w[15:9] == `OP_MULW_HI) begin
        classify = K_MULW;
      end else if (w[15:9] == `OP_NEG_HI) begin
        classify = K_NEG;
      end else begin
        classify = K_NO_OPERATION;
      end
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // operand address
  operand_addr u_addr (
    .file_addr(instr_r[7:0]),
    .access_sel(instr_r[8]),
    .ext_mode(ext_mode_r),
    .bank_sel(bank_sel_r),
    .fsr2(fsr2_r),
    .mem_addr(ex_addr)
  );
  assign busy = q_r != Q_IDLE;
  assign neg_val = ~operand_r + 8'h01;
  assign product = {8'h00, wreg_r} * {8'h00, operand_r};
  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write path
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (aw_hold_r || aw_take) && (w_hold_r || w_take);
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  wire [7:0] wa = aw_hold_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wd = w_hold_r ? w_data_r : s_axi_wdata;
  wire [3:0] ws = w_hold_r ? w_strb_r : s_axi_wstrb;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= illegal_r ? 2'b10 : 2'b00;
      end else begin
        if (aw_take) begin
          aw_hold_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (w_take) begin
          w_hold_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end
  always @* begin
    case (wa)
      `ADDR_CTRL, `ADDR_WREG, `ADDR_BANKSEL, `ADDR_FSR2, `ADDR_INSTR,
      `ADDR_STATUS, `ADDR_PRODUCT_LOW, `ADDR_PRODUCT_HIGH, `ADDR_MEM_ADDR, `ADDR_MEM_DATA: illegal_r = 1'b0;
      default: illegal_r = 1'b1;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // four-phase execution and architectural registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= Q_IDLE;
      kind_r <= K_NO_OPERATION;
      instr_r <= 16'h0000;
      wreg_r <= 8'h00;
      bank_sel_r <= 4'h0;
      fsr2_r <= 12'h000;
      ext_mode_r <= 1'b0;
      status_r <= 5'h00;
      product_low_r <= 8'h00;
      product_high_r <= 8'h00;
      operand_r <= 8'h00;
      result_r <= 16'h0000;
      flags_r <= 5'h00;
      ex_addr_r <= 12'h000;
      mem_addr_r <= 12'h000;
    end else begin
      case (q_r)
        Q_IDLE: begin
          if (wr_fire && wa == `ADDR_INSTR && ws[0]) begin
            instr_r <= wd[15:0];
            q_r <= Q_DECODE;
          end
        end
        Q_DECODE: begin
          kind_r <= classify(instr_r);
          ex_addr_r <= ex_addr;
          q_r <= Q_READ;
        end
        Q_READ: begin
          if (kind_r == K_MULL) begin
            operand_r <= instr_r[7:0];
          end else begin
            operand_r <= mem[ex_addr_r];
          end
          q_r <= Q_PROC;
        end
        Q_PROC: begin
          if (kind_r == K_NEG) begin
            result_r <= {8'h00, neg_val};
            flags_r[`ST_C] <= operand_r == 8'h00;
            flags_r[`ST_DIGIT_CARRY] <= operand_r[3:0] == 4'h0;
            flags_r[`ST_Z] <= neg_val == 8'h00;
            flags_r[`ST_OVERFLOW] <= operand_r == 8'h80;
            flags_r[`ST_N] <= neg_val[7];
          end else begin
            result_r <= product;
          end
          q_r <= Q_WRITE;
        end
        Q_WRITE: begin
          case (kind_r)
            K_MULL, K_MULW: begin
              product_high_r <= result_r[15:8];
              product_low_r <= result_r[7:0];
            end
            K_NEG: begin
              status_r <= flags_r;
            end
            default: begin
            end
          endcase
          q_r <= Q_IDLE;
        end
        default: q_r <= Q_IDLE;
      endcase
      if (q_r == Q_IDLE && wr_fire) begin
        case (wa)
          `ADDR_CTRL: ext_mode_r <= ws[0] ? wd[`CTRL_XINST_BIT] : ext_mode_r;
          `ADDR_WREG: wreg_r <= lane0(wreg_r, wd, ws);
          `ADDR_BANKSEL: bank_sel_r <= ws[0] ? wd[3:0] : bank_sel_r;
          `ADDR_FSR2: fsr2_r <= {ws[1] ? wd[11:8] : fsr2_r[11:8], lane0(fsr2_r[7:0], wd, ws)};
          `ADDR_STATUS: status_r <= ws[0] ? wd[4:0] : status_r;
          `ADDR_PRODUCT_LOW: product_low_r <= lane0(product_low_r, wd, ws);
          `ADDR_PRODUCT_HIGH: product_high_r <= lane0(product_high_r, wd, ws);
          `ADDR_MEM_ADDR: mem_addr_r <= {ws[1] ? wd[11:8] : mem_addr_r[11:8], lane0(mem_addr_r[7:0], wd, ws)};
          default: begin
          end
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // data memory
  always @(posedge aclk) begin
    if (q_r == Q_WRITE && kind_r == K_NEG) begin
      mem[ex_addr_r] <= result_r[7:0];
    end else if (q_r == Q_IDLE && wr_fire && wa == `ADDR_MEM_DATA && ws[0]) begin
      mem[mem_addr_r] <= wd[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `ADDR_CTRL: s_axi_rdata <= {31'h00000000, ext_mode_r};
        `ADDR_WREG: s_axi_rdata <= {24'h000000, wreg_r};
        `ADDR_BANKSEL: s_axi_rdata <= {28'h0000000, bank_sel_r};
        `ADDR_FSR2: s_axi_rdata <= {20'h00000, fsr2_r};
        `ADDR_INSTR: s_axi_rdata <= {15'h0000, busy, instr_r};
        `ADDR_STATUS: s_axi_rdata <= {27'h0000000, status_r};
        `ADDR_PRODUCT_LOW: s_axi_rdata <= {24'h000000, product_low_r};
        `ADDR_PRODUCT_HIGH: s_axi_rdata <= {24'h000000, product_high_r};
        `ADDR_MEM_ADDR: s_axi_rdata <= {20'h00000, mem_addr_r};
        `ADDR_MEM_DATA: s_axi_rdata <= {24'h000000, mem[mem_addr_r]};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* File: mulneg_core_asserts.sv */
// port assertions for the multiply, negate and no-operation datapath
`timescale 1ns/1ps
module mulneg_core_asserts (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus and state
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire busy
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_busy_len: assert property ($rose(busy) |-> busy[*4] ##1 !busy)
    else $error("busy length wrong");
  chk_busy_cause: assert property (
    $rose(busy) |-> $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready))
    else $error("busy without request");
  chk_b_cause: assert property (
    $rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready))
    else $error("response without request");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_r_after: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  chk_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
endmodule
//////////////////////////////////////////
bind mulneg_core mulneg_core_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .busy(busy));

/* File: mulneg_defs.vh */
// constants for the multiply, negate and no-operation datapath
`ifndef MULNEG_DEFS_VH
`define MULNEG_DEFS_VH
`define ADDR_CTRL 8'h00
`define ADDR_WREG 8'h04
`define ADDR_BANKSEL 8'h08
`define ADDR_FSR2 8'h0c
`define ADDR_INSTR 8'h10
`define ADDR_STATUS 8'h14
`define ADDR_PRODUCT_LOW 8'h18
`define ADDR_PRODUCT_HIGH 8'h1c
`define ADDR_MEM_ADDR 8'h20
`define ADDR_MEM_DATA 8'h24
`define CTRL_XINST_BIT 0
`define ST_C 0
`define ST_DIGIT_CARRY 1
`define ST_Z 2
`define ST_OVERFLOW 3
`define ST_N 4
`define OP_MULL_HI 8'h0d
`define OP_MULW_HI 7'h01
`define OP_NEG_HI 7'h36
`define OP_NOPX_NIB 4'hf
`define IDX_LIMIT 8'h5f
`define ACCESS_SPLIT 8'h60
`define ACCESS_SFR_BANK 4'hf
`endif

/* File: multiply_negate_nop_ops_bench.sv */
// self-checking bench for the multiply, negate and no-operation datapath
`timescale 1ns/1ps
`include "mulneg_defs.vh"
module multiply_negate_nop_ops_bench;
  reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ta, tw;
  reg [7:0] awaddr, araddr, o, e;
  reg [31:0] wdata, d;
  reg [1:0] r, ebr;
  reg [11:0] m;
  wire awready, wready, bvalid, arready, rvalid, busy;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer n_fail, n_compared, cyc, i;
  mulneg_core u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .busy(busy));
  always #20 aclk = ~aclk;
  //////////////////////////////////////////
  task give_verdict;
    begin
      if (n_fail == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      n_compared = n_compared + 1;
      if (g !== x) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
        @(negedge aclk);
        ta = ta || awready;
        tw = tw || wready;
        @(posedge aclk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
      end
      @(posedge aclk);
      bready <= 1'b1;
      do @(negedge aclk); while (!bvalid);
      chk({30'h0, bresp}, {30'h0, ebr});
      @(posedge aclk);
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] q, output [1:0] s);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      rready <= 1'b1;
      do @(negedge aclk); while (!rvalid);
      q = rdata;
      s = rresp;
      @(posedge aclk);
      rready <= 1'b0;
    end
  endtask
  task ck(input [7:0] a, input [31:0] x);
    begin
      rd(a, d, r);
      chk(d, x);
    end
  endtask
  task sm(input [11:0] a, input [7:0] v);
    begin
      wr(`ADDR_MEM_ADDR, {20'h0, a});
      wr(`ADDR_MEM_DATA, {24'h0, v});
    end
  endtask
  task gm(input [11:0] a, input [7:0] v);
    begin
      wr(`ADDR_MEM_ADDR, {20'h0, a});
      ck(`ADDR_MEM_DATA, {24'h0, v});
    end
  endtask
  task ex(input [15:0] c);
    begin
      wr(`ADDR_INSTR, {16'h0, c});
      @(negedge aclk);
      chk({31'h0, busy}, 32'h1);
      do rd(`ADDR_INSTR, d, r); while (d[16] !== 1'b0);
    end
  endtask
  //////////////////////////////////////////
  task t_mul;
    begin
      wr(`ADDR_WREG, 32'he2);
      wr(`ADDR_STATUS, 32'h1f);
      ex(16'h0dc4);
      ck(`ADDR_PRODUCT_HIGH, 32'had);
      ck(`ADDR_PRODUCT_LOW, 32'h08);
      ck(`ADDR_WREG, 32'he2);
      ck(`ADDR_STATUS, 32'h1f);
      wr(`ADDR_STATUS, 32'h0);
      ex(16'h0d00);
      ck(`ADDR_PRODUCT_LOW, 32'h0);
      ck(`ADDR_STATUS, 32'h0);
      wr(`ADDR_BANKSEL, 32'h3);
      sm(12'h345, 8'hb5);
      sm(12'h045, 8'h01);
      wr(`ADDR_WREG, 32'hc4);
      wr(`ADDR_STATUS, 32'h15);
      ex(16'h0345);
      ck(`ADDR_PRODUCT_HIGH, 32'h8a);
      ck(`ADDR_PRODUCT_LOW, 32'h94);
      ck(`ADDR_WREG, 32'hc4);
      ck(`ADDR_STATUS, 32'h15);
      gm(12'h345, 8'hb5);
    end
  endtask
  task t_neg;
    for (i = 0; i < 5; i = i + 1) begin
      o = (i == 0) ? 8'h3a : (i == 1) ? 8'h00 : (i == 2) ? 8'h80 : (i == 3) ? 8'h01 : 8'h7f;
      m = (i == 4) ? 12'h345 : i[0] ? 12'hf70 : 12'h020;
      e = ~o + 8'h01;
      sm(m, o);
      ex({7'h36, i == 4, m[7:0]});
      gm(m, e);
      ck(`ADDR_STATUS, {27'h0, e[7], o == 8'h80, e == 8'h00, o[3:0] == 4'h0, o == 8'h00});
    end
  endtask
  task t_ext;
    begin
      wr(`ADDR_CTRL, 32'h1);
      wr(`ADDR_FSR2, 32'h200);
      wr(`ADDR_WREG, 32'h03);
      sm(12'h25f, 8'h07);
      sm(12'h05f, 8'h09);
      ex(16'h025f);
      ck(`ADDR_PRODUCT_LOW, 32'h15);
      sm(12'hf60, 8'h05);
      ex(16'h0260);
      ck(`ADDR_PRODUCT_LOW, 32'h0f);
      wr(`ADDR_STATUS, 32'h0a);
      ex(16'h0000);
      ex(16'hf123);
      ck(`ADDR_STATUS, 32'h0a);
      ck(`ADDR_PRODUCT_LOW, 32'h0f);
      ck(`ADDR_WREG, 32'h03);
    end
  endtask
  task t_busy;
    begin
      fork
        wr(`ADDR_INSTR, 32'h0d09);
        begin
          @(posedge aclk);
          rd(`ADDR_INSTR, d, r);
        end
      join
      chk({31'h0, d[16]}, 32'h1);
      ck(`ADDR_PRODUCT_LOW, 32'h1b);
      ebr = 2'b10;
      wr(8'h30, 32'h55);
      ebr = 2'b00;
      rd(8'h30, d, r);
      chk({r, d[29:0]}, 32'h80000000);
    end
  endtask
  //////////////////////////////////////////
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    ebr = 2'b00;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_mul;
    t_neg;
    t_ext;
    t_busy;
    give_verdict;
  end
endmodule

/* File: operand_addr.v */
// data memory address generation for register operands
`timescale 1ns/1ps
`include "mulneg_defs.vh"
module operand_addr (
  // operand fields
  input wire [7:0] file_addr,
  input wire access_sel,
  // mode and pointers
  input wire ext_mode,
  input wire [3:0] bank_sel,
  input wire [11:0] fsr2,
  // resolved address
  output reg [11:0] mem_addr
);
  always @* begin
    if (access_sel) begin
      mem_addr = {bank_sel, file_addr};
    end else if (ext_mode && file_addr <= `IDX_LIMIT) begin
      mem_addr = fsr2 + {4'h0, file_addr};
    end else if (file_addr < `ACCESS_SPLIT) begin
      mem_addr = {4'h0, file_addr};
    end else begin
      mem_addr = {`ACCESS_SFR_BANK, file_addr};
    end
  end
endmodule
